// ---- include/ecgfe_pkg.sv ----
// constants for the front end main control register and its serial port
// assumes a host that sends 32-bit command words over a four-wire port
package ecgfe_pkg;

    // command word layout
    localparam int          CMD_W          = 32;
    localparam int          RW_BIT         = 31;
    localparam int          ADDR_HI        = 30;
    localparam int          ADDR_LO        = 24;
    localparam int          ADDR_W         = 7;
    localparam int          DATA_W         = 24;
    localparam logic [4:0]  LAST_BIT_CNT   = 5'h1F;
    localparam logic [4:0]  BIT_CNT_RESET  = 5'h00;

    // register addresses
    localparam logic [6:0]  ADDR_NOP       = 7'h00;
    localparam logic [6:0]  ADDR_MAIN_CTL  = 7'h01;

    // values after reset
    localparam logic [23:0] MAIN_CTL_RESET = 24'h000000;
    localparam logic [31:0] READBACK_RESET = 32'h00000000;

    // writable bits; reserved 18..11 and the self-clearing bit 0 stay zero
    localparam logic [23:0] MAIN_CTL_WMASK = 24'hF807FE;

    // field positions in front_end_main_control
    localparam int LEFT_ARM_POS   = 23;
    localparam int LEFT_LEG_POS   = 22;
    localparam int RIGHT_ARM_POS  = 21;
    localparam int CHEST1_POS     = 20;
    localparam int CHEST2_POS     = 19;
    localparam int CHAN_LO        = 19;
    localparam int RSVD_HI        = 18;
    localparam int RSVD_LO        = 11;
    localparam int DIFF_POS       = 10;
    localparam int GAIN_HI        = 9;
    localparam int GAIN_LO        = 8;
    localparam int VREF_POS       = 7;
    localparam int EXT_CLK_POS    = 6;
    localparam int MASTER_POS     = 5;
    localparam int GANG_POS       = 4;
    localparam int HIGH_RATE_POS  = 3;
    localparam int CONV_POS       = 2;
    localparam int POWER_POS      = 1;
    localparam int SOFT_RST_POS   = 0;

    // preamplifier gain codes
    localparam logic [1:0] GAIN_X1P4 = 2'h0;
    localparam logic [1:0] GAIN_X2P1 = 2'h1;
    localparam logic [1:0] GAIN_X2P8 = 2'h2;
    localparam logic [1:0] GAIN_X4P2 = 2'h3;

endpackage

// ---- core/ecgfe_sync.sv ----
// two-flop level synchroniser, one per bit
// assumes each input bit is a level that stays for at least two clk edges
`timescale 1ns/1ps
`default_nettype none
module ecgfe_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ecgfe_sync_t;

    ecgfe_sync_t s_r;
    ecgfe_sync_t s_nxt;

    // the first stage feeds only the second
    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            s_nxt.meta   = d;
            s_nxt.stable = s_r.meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;
endmodule
`default_nettype wire

// ---- core/ecgfe_main_control.sv ----
// front end main control register with its serial command port
// assumes sclk idles between frames, words are 32 bits, cs_n low per frame
//
// Operation
// RULE1 - word: rw flag, 7-bit address, 24 data
// RULE2 - register resets to zero, also on soft reset
// RULE3 - five channel enables, cleared means channel off
// RULE4 - bit 10 selects differential inputs
// RULE5 - two-bit gain; top code needs calibration
// RULE6 - host sets reference buffer for internal reference
// RULE7 - bit 6 selects external clock over crystal
// RULE8 - ganged slave on master clock stops crystal
// RULE9 - bit 5 master drives sync, only in gang
// RULE10 - bit 4 gang activates clock and sync pins
// RULE11 - bit 3 picks 2 MSPS over 1 MSPS
// RULE12 - bit 2 runs conversion and filters
// RULE13 - bit 1 clear powers analog down, keeps registers
// RULE14 - writing bit 0 resets registers, self clears
// RULE15 - host sends a no-op to finish reset
// RULE16 - reserved bits 18..11 read back zero
`timescale 1ns/1ps
`default_nettype none
module ecgfe_main_control
    import ecgfe_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output var  logic       sdo,
    output var  logic       left_arm_channel_on,
    output var  logic       left_leg_channel_on,
    output var  logic       right_arm_channel_on,
    output var  logic       chest1_channel_on,
    output var  logic       chest2_channel_on,
    output var  logic       differential_input_select,
    output var  logic [1:0] preamp_gain,
    output var  logic       gain_calibration_needed,
    output var  logic       reference_buffer_on,
    output var  logic       external_clock_select,
    output var  logic       gang_master_select,
    output var  logic       gang_mode_enable,
    output var  logic       crystal_oscillator_enable,
    output var  logic       clk_io_out_en,
    output var  logic       sync_out_en,
    output var  logic       high_sample_rate_select,
    output var  logic       conversion_active,
    output var  logic       power_on_control,
    output var  logic       soft_reset_busy
);

    // ---------------- link side, on sclk ----------------
    typedef struct packed {
        logic [4:0]  cnt;
        logic [30:0] shift;
        logic        sdo;
    } ecgfe_frame_t;

    typedef struct packed {
        logic [31:0] word;
        logic        tgl;
    } ecgfe_capture_t;

    ecgfe_frame_t   f_r;
    ecgfe_frame_t   f_nxt;
    ecgfe_capture_t k_r;
    ecgfe_capture_t k_nxt;
    logic           frame_rst_n;

    // raising cs_n aborts a partial word
    assign frame_rst_n = rst_n & ~cs_n;

    typedef struct packed {
        logic [23:0] ctl;
        logic [31:0] rb;
        logic        busy;
        logic        tgl_seen;
        logic [4:0]  chan;
        logic        diff;
        logic [1:0]  gain;
        logic        gain_cal;
        logic        vref;
        logic        ext;
        logic        master;
        logic        gang;
        logic        crystal_oscillator;
        logic        clkio_oe;
        logic        sync_oe;
        logic        hp;
        logic        conv;
        logic        pwr;
    } ecgfe_core_t;

    ecgfe_core_t c_r;
    ecgfe_core_t c_nxt;

    // bits go in msb first; readback goes out msb first, one per rising edge
    always_comb begin
        f_nxt       = f_r;
        f_nxt.shift = {f_r.shift[29:0], sdi};                     // [RULE1]
        f_nxt.cnt   = f_r.cnt + 5'h01;
        f_nxt.sdo   = c_r.rb[~f_r.cnt];
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f_r <= '{cnt: BIT_CNT_RESET, shift: '0, sdo: 1'b0};
        end else begin
            f_r <= f_nxt;
        end
    end

    // a full word is held and announced by a toggle
    always_comb begin
        k_nxt = k_r;
        if (!cs_n && f_r.cnt == LAST_BIT_CNT) begin
            k_nxt.word = {f_r.shift, sdi};                        // [RULE1]
            k_nxt.tgl  = ~k_r.tgl;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            k_r <= '0;
        end else begin
            k_r <= k_nxt;
        end
    end

    // ---------------- register side, on clk ----------------
    logic              tgl_sync;
    logic              cmd_new;
    logic              cmd_fire;
    logic              cmd_write;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;

    ecgfe_sync #(
        .W (1)
    ) u_tgl_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (k_r.tgl),
        .q     (tgl_sync)
    );

    // word is stable long before the toggle gets through
    assign cmd_new   = tgl_sync ^ c_r.tgl_seen;
    assign cmd_fire  = cmd_new & ce;
    assign cmd_write = k_r.word[RW_BIT];                           // [RULE1]
    assign cmd_addr  = k_r.word[ADDR_HI:ADDR_LO];
    assign cmd_data  = k_r.word[DATA_W-1:0];

    always_comb begin
        c_nxt = c_r;
        if (ce) begin
            c_nxt.tgl_seen = tgl_sync;
            if (cmd_new) begin
                if (cmd_write) begin
                    if (cmd_addr == ADDR_MAIN_CTL) begin
                        if (cmd_data[SOFT_RST_POS]) begin
                            // soft reset back to defaults, bit never stored
                            c_nxt.ctl  = MAIN_CTL_RESET;          // [RULE14] [RULE2]
                            c_nxt.rb   = READBACK_RESET;
                            c_nxt.busy = 1'b1;
                        end else begin
                            c_nxt.ctl = cmd_data & MAIN_CTL_WMASK; // [RULE16]
                        end
                    end
                end else begin
                    c_nxt.rb = {1'b0, cmd_addr, {DATA_W{1'b0}}};
                    if (cmd_addr == ADDR_MAIN_CTL) begin
                        c_nxt.rb[DATA_W-1:0] = c_r.ctl;           // [RULE16]
                    end
                    if (cmd_addr == ADDR_NOP) begin
                        c_nxt.busy = 1'b0;                        // [RULE15]
                    end
                end
            end
            // decoded controls follow the register; power gates analog
            c_nxt.chan = c_nxt.ctl[LEFT_ARM_POS:CHAN_LO]
                       & {5{c_nxt.ctl[POWER_POS]}};               // [RULE3] [RULE13]
            c_nxt.diff     = c_nxt.ctl[DIFF_POS];                 // [RULE4]
            c_nxt.gain     = c_nxt.ctl[GAIN_HI:GAIN_LO];          // [RULE5]
            c_nxt.gain_cal = (c_nxt.ctl[GAIN_HI:GAIN_LO] == GAIN_X4P2);
            c_nxt.vref     = c_nxt.ctl[VREF_POS] & c_nxt.ctl[POWER_POS];
            c_nxt.ext      = c_nxt.ctl[EXT_CLK_POS];              // [RULE7]
            c_nxt.master   = c_nxt.ctl[MASTER_POS];
            c_nxt.gang     = c_nxt.ctl[GANG_POS];                 // [RULE10]
            c_nxt.crystal_oscillator     = c_nxt.ctl[POWER_POS]
                           & ~(c_nxt.ctl[GANG_POS]
                               & ~c_nxt.ctl[MASTER_POS]
                               & c_nxt.ctl[EXT_CLK_POS]);         // [RULE8] [RULE13]
            c_nxt.clkio_oe = c_nxt.ctl[GANG_POS]
                           & c_nxt.ctl[MASTER_POS]
                           & ~c_nxt.ctl[EXT_CLK_POS];             // [RULE10]
            c_nxt.sync_oe  = c_nxt.ctl[GANG_POS]
                           & c_nxt.ctl[MASTER_POS];               // [RULE9]
            c_nxt.hp       = c_nxt.ctl[HIGH_RATE_POS];            // [RULE11]
            c_nxt.conv     = c_nxt.ctl[CONV_POS]
                           & c_nxt.ctl[POWER_POS];                // [RULE12]
            c_nxt.pwr      = c_nxt.ctl[POWER_POS];                // [RULE13]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_r <= '0;                                            // [RULE2]
        end else begin
            c_r <= c_nxt;
        end
    end

    assign sdo                       = f_r.sdo;
    assign left_arm_channel_on       = c_r.chan[4];
    assign left_leg_channel_on       = c_r.chan[3];
    assign right_arm_channel_on      = c_r.chan[2];
    assign chest1_channel_on         = c_r.chan[1];
    assign chest2_channel_on         = c_r.chan[0];
    assign differential_input_select = c_r.diff;
    assign preamp_gain               = c_r.gain;
    assign gain_calibration_needed   = c_r.gain_cal;
    assign reference_buffer_on       = c_r.vref;
    assign external_clock_select     = c_r.ext;
    assign gang_master_select        = c_r.master;
    assign gang_mode_enable          = c_r.gang;
    assign crystal_oscillator_enable = c_r.crystal_oscillator;
    assign clk_io_out_en             = c_r.clkio_oe;
    assign sync_out_en               = c_r.sync_oe;
    assign high_sample_rate_select   = c_r.hp;
    assign conversion_active         = c_r.conv;
    assign power_on_control          = c_r.pwr;
    assign soft_reset_busy           = c_r.busy;

    // ---------------- checks ----------------
    logic wr_main;
    logic wr_soft;
    logic wr_other;
    logic rd_nop;

    assign wr_main  = cmd_fire & cmd_write & (cmd_addr == ADDR_MAIN_CTL)
                    & ~cmd_data[SOFT_RST_POS];
    assign wr_soft  = cmd_fire & cmd_write & (cmd_addr == ADDR_MAIN_CTL)
                    & cmd_data[SOFT_RST_POS];
    assign wr_other = cmd_fire & cmd_write & (cmd_addr != ADDR_MAIN_CTL);
    assign rd_nop   = cmd_fire & ~cmd_write & (cmd_addr == ADDR_NOP);

    // looked at on the falling edge, while the frame is still open
    property p_word_toggle;
        @(negedge sclk) disable iff (!rst_n || cs_n)
        (f_r.cnt == BIT_CNT_RESET) |-> (k_r.tgl != $past(k_r.tgl));
    endproperty
    a_word_toggle: assert property (p_word_toggle) // [RULE1]
        else $error("full word did not raise a command");

    property p_write_stores;
        @(posedge clk) disable iff (!rst_n)
        wr_main |=> (c_r.ctl == ($past(cmd_data) & MAIN_CTL_WMASK));
    endproperty
    a_write_stores: assert property (p_write_stores) // [RULE1]
        else $error("write to control register not stored");

    property p_soft_reset;
        @(posedge clk) disable iff (!rst_n)
        wr_soft |=> (c_r.ctl == MAIN_CTL_RESET) && c_r.busy
                    && !power_on_control && !conversion_active;
    endproperty
    a_soft_reset: assert property (p_soft_reset) // [RULE14]
        else $error("soft reset did not clear the register");

    property p_other_ignored;
        @(posedge clk) disable iff (!rst_n)
        wr_other |=> $stable(c_r.ctl);
    endproperty
    a_other_ignored: assert property (p_other_ignored) // [RULE2]
        else $error("write to another address changed the register");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        (c_r.ctl[RSVD_HI:RSVD_LO] == 8'h00) && !c_r.ctl[SOFT_RST_POS];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE16]
        else $error("reserved or reset bit held a one");

    property p_power_down;
        @(posedge clk) disable iff (!rst_n)
        !c_r.ctl[POWER_POS] |-> (c_r.chan == 5'h00) && !c_r.crystal_oscillator
                                 && !c_r.conv;
    endproperty
    a_power_down: assert property (p_power_down) // [RULE13]
        else $error("analog block active while powered down");

    property p_channel_on;
        @(posedge clk) disable iff (!rst_n)
        c_r.ctl[POWER_POS] |-> (c_r.chan == c_r.ctl[LEFT_ARM_POS:CHAN_LO]);
    endproperty
    a_channel_on: assert property (p_channel_on) // [RULE3]
        else $error("channel enable does not follow its bit");

    property p_slave_crystal_oscillator;
        @(posedge clk) disable iff (!rst_n)
        (c_r.ctl[GANG_POS] && !c_r.ctl[MASTER_POS] && c_r.ctl[EXT_CLK_POS])
        |-> !crystal_oscillator_enable;
    endproperty
    a_slave_crystal_oscillator: assert property (p_slave_crystal_oscillator) // [RULE8]
        else $error("crystal running on a ganged slave");

    property p_sync_pin;
        @(posedge clk) disable iff (!rst_n)
        sync_out_en |-> gang_mode_enable && gang_master_select;
    endproperty
    a_sync_pin: assert property (p_sync_pin) // [RULE9]
        else $error("sync pin driven outside gang master");

    property p_standalone;
        @(posedge clk) disable iff (!rst_n)
        !c_r.ctl[GANG_POS] |-> !clk_io_out_en && !sync_out_en;
    endproperty
    a_standalone: assert property (p_standalone) // [RULE10]
        else $error("gang pins active in standalone mode");

    property p_conversion;
        @(posedge clk) disable iff (!rst_n)
        wr_main && $past(ce) ##0 cmd_data[CONV_POS] && cmd_data[POWER_POS]
        |=> conversion_active;
    endproperty
    a_conversion: assert property (p_conversion) // [RULE12]
        else $error("conversion not started by its bit");

    property p_rate_gain;
        @(posedge clk) disable iff (!rst_n)
        (high_sample_rate_select == c_r.ctl[HIGH_RATE_POS])
        && (gain_calibration_needed == (preamp_gain == GAIN_X4P2))
        && (differential_input_select == c_r.ctl[DIFF_POS])
        && (external_clock_select == c_r.ctl[EXT_CLK_POS]);
    endproperty
    a_rate_gain: assert property (p_rate_gain) // [RULE11] [RULE5] [RULE4] [RULE7]
        else $error("decoded control out of step with register");

    property p_nop_done;
        @(posedge clk) disable iff (!rst_n)
        rd_nop |=> !soft_reset_busy;
    endproperty
    a_nop_done: assert property (p_nop_done) // [RULE15]
        else $error("no-op did not finish the soft reset");

    cover property (@(posedge clk) disable iff (!rst_n) wr_main);
    cover property (@(posedge clk) disable iff (!rst_n)
        wr_soft ##[1:1000] rd_nop);
    cover property (@(posedge clk) disable iff (!rst_n)
        cmd_fire && !cmd_write && cmd_addr == ADDR_MAIN_CTL);
    cover property (@(posedge clk) disable iff (!rst_n)
        sync_out_en && clk_io_out_en);

endmodule
`default_nettype wire

// ---- verification/ecgfe_host_model.sv ----
// host side serial master for the main control register port
// assumes sdo is sampled on falling sclk; sclk stands still between frames
`timescale 1ns/1ps
`default_nettype none
module ecgfe_host_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // one framed 32-bit word at 160 ns per bit; rx gets what sdo shifted out
    task automatic xfer(input logic [31:0] w, output logic [31:0] rx);
        cs_n = 1'b0;
        #40;
        for (int i = 31; i >= 0; i--) begin
            sdi = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
            rx[i] = sdo;
        end
        #40 cs_n = 1'b1;
        // a released line must not keep showing its last bit
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// ---- verification/ecg_front_end_control_register_tb.sv ----
// self-checking bench for the front end main control register
// assumes the host model frames words and the send task waits out the command latency
`timescale 1ns/1ps
`default_nettype none
module ecg_front_end_control_register_tb;
    import ecgfe_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic        left_arm_channel_on;
    logic        left_leg_channel_on;
    logic        right_arm_channel_on;
    logic        chest1_channel_on;
    logic        chest2_channel_on;
    logic        differential_input_select;
    logic [1:0]  preamp_gain;
    logic        gain_calibration_needed;
    logic        reference_buffer_on;
    logic        external_clock_select;
    logic        gang_master_select;
    logic        gang_mode_enable;
    logic        crystal_oscillator_enable;
    logic        clk_io_out_en;
    logic        sync_out_en;
    logic        high_sample_rate_select;
    logic        conversion_active;
    logic        power_on_control;
    logic        soft_reset_busy;
    logic [19:0] outs;
    int          n_mismatch;
    int          n_compared;

    assign outs = {left_arm_channel_on, left_leg_channel_on,
        right_arm_channel_on, chest1_channel_on, chest2_channel_on,
        differential_input_select, preamp_gain, gain_calibration_needed,
        reference_buffer_on, external_clock_select, gang_master_select,
        gang_mode_enable, crystal_oscillator_enable, clk_io_out_en,
        sync_out_en, high_sample_rate_select, conversion_active,
        power_on_control, soft_reset_busy};

    ecgfe_main_control i_dut (
        .clk, .rst_n, .ce, .sclk, .cs_n, .sdi, .sdo,
        .left_arm_channel_on, .left_leg_channel_on, .right_arm_channel_on,
        .chest1_channel_on, .chest2_channel_on, .differential_input_select,
        .preamp_gain, .gain_calibration_needed, .reference_buffer_on,
        .external_clock_select, .gang_master_select, .gang_mode_enable,
        .crystal_oscillator_enable, .clk_io_out_en, .sync_out_en,
        .high_sample_rate_select, .conversion_active, .power_on_control,
        .soft_reset_busy
    );

    ecgfe_host_model i_host (
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi),
        .sdo  (sdo)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // expected port levels for a stored register value and busy flag
    function automatic logic [19:0] exp_outs(input logic [23:0] c,
                                             input logic b);
        logic p;
        p = c[POWER_POS];
        return {c[23:19] & {5{p}}, c[DIFF_POS], c[9:8], &c[9:8], c[7] & p,
                c[6], c[5], c[4], p & ~(c[4] & ~c[5] & c[6]),
                c[4] & c[5] & ~c[6], c[4] & c[5], c[3], c[2] & p, p, b};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one word, then enough clk cycles for the command to take effect
    task automatic send(input logic rw, input logic [6:0] a,
                        input logic [23:0] d, output logic [31:0] rx);
        i_host.xfer({rw, a, d}, rx);
        wait_clk(8);
    endtask

    // outputs and register readback; the read answers in the next word
    task automatic chk_state(input logic [23:0] s, input logic b);
        logic [31:0] rx;
        chk("outputs", {12'h000, exp_outs(s, b)}, {12'h000, outs});
        send(1'b0, ADDR_MAIN_CTL, 24'h000000, rx);
        send(1'b0, ADDR_MAIN_CTL, 24'h000000, rx);
        chk("readback", {8'h01, s}, rx);
    endtask

    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        logic [31:0] rx;
        send(1'b1, a, d, rx);
    endtask

    task automatic t_write_all;
        wr(ADDR_MAIN_CTL, 24'hFFFFFE);
        chk_state(24'hF807FE, 1'b0);
    endtask

    task automatic t_gain;
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_MAIN_CTL, 24'h000082 | (24'(g) << GAIN_LO));
            chk_state(24'h000082 | (24'(g) << GAIN_LO), 1'b0);
        end
    endtask

    task automatic t_clock;
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_MAIN_CTL, {17'h00000, 3'(k), 4'h2});
            chk_state({17'h00000, 3'(k), 4'h2}, 1'b0);
        end
    endtask

    task automatic t_power;
        wr(ADDR_MAIN_CTL, 24'hF8008C);
        chk_state(24'hF8008C, 1'b0);
        wr(ADDR_MAIN_CTL, 24'hF8000E);
        chk_state(24'hF8000E, 1'b0);
    endtask

    task automatic t_refused;
        wr(7'h02, 24'hFFFFFF);
        chk_state(24'hF8000E, 1'b0);
    endtask

    task automatic t_soft_reset;
        logic [31:0] rx;
        wr(ADDR_MAIN_CTL, 24'hF807FF);
        chk_state(24'h000000, 1'b1);
        send(1'b0, ADDR_NOP, 24'h000000, rx);
        chk_state(24'h000000, 1'b0);
    endtask

    // a word sent while ce is low waits until ce returns
    task automatic t_clock_enable;
        logic [31:0] rx;
        ce = 1'b0;
        send(1'b1, ADDR_MAIN_CTL, 24'h000006, rx);
        chk("frozen", {12'h000, exp_outs(24'h000000, 1'b0)}, {12'h000, outs});
        ce = 1'b1;
        wait_clk(8);
        chk_state(24'h000006, 1'b0);
    endtask

    // reset in mid-run, with the link idle
    task automatic t_hard_reset;
        wr(ADDR_MAIN_CTL, 24'hF8000E);
        rst_n = 1'b0;
        wait_clk(3);
        rst_n = 1'b1;
        wait_clk(2);
        chk_state(MAIN_CTL_RESET, 1'b0);
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        complete_run;
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        wait_clk(2);
        chk_state(MAIN_CTL_RESET, 1'b0);
        t_write_all;
        t_gain;
        t_clock;
        t_power;
        t_refused;
        t_soft_reset;
        t_clock_enable;
        t_hard_reset;
        complete_run;
    end
endmodule
`default_nettype wire
